// [core/fir_sink_pkg.sv]
/*
 holds the shared constants of the filter sink port: slot layout, defaults, reset values.
 assumes both ends and the interface compile after it.
*/
package fir_sink_pkg;
    // ***************************************************
    // layout defaults
    // ***************************************************
    localparam int SAMPLE_WIDTH = 8;
    localparam int COEFF_SETS = 4;
    localparam int INPUT_WIRE_COUNT = 3;
    localparam int CHANNEL_COUNT = 6;
    localparam int BANK_WIDTH = (COEFF_SETS > 1) ? $clog2(COEFF_SETS) : 1;
    localparam int SLOT_WIDTH = SAMPLE_WIDTH + BANK_WIDTH;
    localparam int SAMPLE_LSB = 0;
    localparam int BANK_LSB = SAMPLE_WIDTH;
    localparam bit BACKPRESSURE = 1'b1;
    // ***************************************************
    // reset values
    // ***************************************************
    localparam logic RST_VALID = 1'b0;
    localparam logic RST_READY = 1'b0;
    localparam logic RST_RELOAD_BUSY = 1'b0;
endpackage : fir_sink_pkg

// [core/fir_sink_if.sv]
/*
 holds the streaming link between the upstream source and the filter sink port.
 assumes both ends share sys_clk_i; the testbench joins them.
*/
`timescale 1ns/1ps
`default_nettype none
interface fir_sink_if #(
    parameter int SLOT_WIDTH = fir_sink_pkg::SLOT_WIDTH,
    parameter int WIRES = fir_sink_pkg::INPUT_WIRE_COUNT
);
    logic valid;
    logic ready;
    logic sop;
    logic eop;
    logic [SLOT_WIDTH*WIRES-1:0] data;
    modport filter (input valid, input sop, input eop, input data, output ready);
    modport source (output valid, output sop, output eop, output data, input ready);
endinterface : fir_sink_if
`default_nettype wire

// [core/fir_sink_source.sv]
/*
 holds the upstream source end: packs per-wire samples and banks into slots, marks groups.
 assumes a user side that offers one beat at a time and holds it until taken.
*/
`timescale 1ns/1ps
`default_nettype none
module fir_sink_source #(
    parameter int SAMPLE_WIDTH = fir_sink_pkg::SAMPLE_WIDTH,
    parameter int BANK_WIDTH = fir_sink_pkg::BANK_WIDTH,
    parameter int WIRES = fir_sink_pkg::INPUT_WIRE_COUNT,
    parameter int BEATS_PER_GROUP = fir_sink_pkg::CHANNEL_COUNT / fir_sink_pkg::INPUT_WIRE_COUNT
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic beat_valid_i,
    input wire logic [SAMPLE_WIDTH*WIRES-1:0] beat_samples_i,
    input wire logic [BANK_WIDTH*WIRES-1:0] beat_banks_i,
    output logic beat_taken_o,
    fir_sink_if.source link
);
    localparam int SLOT = SAMPLE_WIDTH + BANK_WIDTH;
    localparam int CW = (BEATS_PER_GROUP > 1) ? $clog2(BEATS_PER_GROUP) : 1;
    localparam logic [CW-1:0] LAST_BEAT = CW'(BEATS_PER_GROUP - 1);

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [SLOT*WIRES-1:0] data;
        logic [CW-1:0] beat;
        logic taken;
    } src_state_s;

    src_state_s state_ff;
    src_state_s nxt_state;
    logic [SLOT*WIRES-1:0] packed_data;

    // ***************************************************
    // slot packing
    // ***************************************************
    genvar w;
    generate
        for (w = 0; w < WIRES; w++) begin : g_pack
            assign packed_data[w*SLOT +: SLOT] = {beat_banks_i[w*BANK_WIDTH +: BANK_WIDTH],
                                                  beat_samples_i[w*SAMPLE_WIDTH +: SAMPLE_WIDTH]};
        end
    endgenerate

    // ***************************************************
    // handshake
    // ***************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.taken = 1'b0;
        if (state_ff.valid && link.ready) begin
            nxt_state.valid = 1'b0;
            nxt_state.taken = 1'b1;
            nxt_state.beat = (state_ff.beat == LAST_BEAT) ? '0 : CW'(state_ff.beat + 1'b1);
        end
        // one beat in flight; taken pulse keeps the user from reoffering the same beat
        if (!nxt_state.valid && beat_valid_i && !nxt_state.taken) begin
            nxt_state.valid = 1'b1;
            nxt_state.data = packed_data;
            nxt_state.sop = (nxt_state.beat == '0);
            nxt_state.eop = (nxt_state.beat == LAST_BEAT);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign link.valid = state_ff.valid;
    assign link.sop = state_ff.sop;
    assign link.eop = state_ff.eop;
    assign link.data = state_ff.data;
    assign beat_taken_o = state_ff.taken;
endmodule : fir_sink_source
`default_nettype wire

// [core/fir_sink_filter.sv]
/*
 holds the filter end of the sink port: handshake, slot split, channel tracking,
 and the coefficient reload domain's reset and busy crossing.
 assumes the source keeps valid high with meaningful data and eop on the last channel.
*/
`timescale 1ns/1ps
`default_nettype none
module fir_sink_filter #(
    parameter int SAMPLE_WIDTH = fir_sink_pkg::SAMPLE_WIDTH,
    parameter int BANK_WIDTH = fir_sink_pkg::BANK_WIDTH,
    parameter int WIRES = fir_sink_pkg::INPUT_WIRE_COUNT,
    parameter int BEATS_PER_GROUP = fir_sink_pkg::CHANNEL_COUNT / fir_sink_pkg::INPUT_WIRE_COUNT,
    parameter bit BACKPRESSURE = fir_sink_pkg::BACKPRESSURE
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic coeff_clk_i,
    input wire logic coeff_rst_i,
    input wire logic coeff_load_i,
    input wire logic datapath_stall_i,
    output logic [SAMPLE_WIDTH*WIRES-1:0] wire_sample_o,
    output logic [BANK_WIDTH*WIRES-1:0] wire_bank_select_o,
    output logic wire_valid_o,
    output logic [7:0] beat_index_o,
    output logic group_start_o,
    output logic group_end_o,
    output logic reload_busy_o,
    fir_sink_if.filter link
);
    localparam int SLOT = SAMPLE_WIDTH + BANK_WIDTH;

    typedef struct packed {
        logic ready;
        logic valid;
        logic [SAMPLE_WIDTH*WIRES-1:0] sample;
        logic [BANK_WIDTH*WIRES-1:0] bank;
        logic [7:0] beat;
        logic start;
        logic stop;
        logic [1:0] busy_sync;
        logic busy;
    } filt_state_s;

    typedef struct packed {
        logic busy;
    } coeff_state_s;

    filt_state_s state_ff;
    filt_state_s nxt_state;
    coeff_state_s coeff_ff;
    coeff_state_s nxt_coeff;
    logic [SAMPLE_WIDTH*WIRES-1:0] split_sample;
    logic [BANK_WIDTH*WIRES-1:0] split_bank;
    logic accept;
    logic can_accept;

    // ***************************************************
    // slot split
    // ***************************************************
    genvar w;
    generate
        for (w = 0; w < WIRES; w++) begin : g_split
            assign split_sample[w*SAMPLE_WIDTH +: SAMPLE_WIDTH] =
                link.data[w*SLOT + fir_sink_pkg::SAMPLE_LSB +: SAMPLE_WIDTH];
            assign split_bank[w*BANK_WIDTH +: BANK_WIDTH] =
                link.data[w*SLOT + SAMPLE_WIDTH +: BANK_WIDTH];
        end
    endgenerate

    // ***************************************************
    // handshake and channel tracking
    // ***************************************************
    // ready registered for clean timing; it reflects next cycle's ability to accept
    assign can_accept = !datapath_stall_i && !state_ff.busy;
    assign accept = link.valid && (BACKPRESSURE ? state_ff.ready : 1'b1);

    always_comb begin
        nxt_state = state_ff;
        nxt_state.ready = BACKPRESSURE ? can_accept : 1'b1;
        nxt_state.valid = accept;
        nxt_state.busy_sync = {state_ff.busy_sync[0], coeff_ff.busy};
        nxt_state.busy = state_ff.busy_sync[1];
        if (accept) begin
            nxt_state.sample = split_sample;
            nxt_state.bank = split_bank;
            nxt_state.start = link.sop;
            nxt_state.stop = link.eop;
            if (link.sop) begin
                nxt_state.beat = '0;
            end else if (state_ff.stop || state_ff.beat == 8'(BEATS_PER_GROUP - 1)) begin
                nxt_state.beat = '0;
            end else begin
                nxt_state.beat = state_ff.beat + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ***************************************************
    // coefficient reload domain
    // ***************************************************
    // reload internals live elsewhere; only its busy level crosses to stall the sink
    always_comb begin
        nxt_coeff = coeff_ff;
        nxt_coeff.busy = coeff_load_i;
    end

    always_ff @(posedge coeff_clk_i or posedge coeff_rst_i) begin
        if (coeff_rst_i) begin
            coeff_ff <= '0;
        end else begin
            coeff_ff <= nxt_coeff;
        end
    end

    assign link.ready = state_ff.ready;
    assign wire_sample_o = state_ff.sample;
    assign wire_bank_select_o = state_ff.bank;
    assign wire_valid_o = state_ff.valid;
    assign beat_index_o = state_ff.beat;
    assign group_start_o = state_ff.start;
    assign group_end_o = state_ff.stop;
    assign reload_busy_o = state_ff.busy;
endmodule : fir_sink_filter
`default_nettype wire

// [sim/fir_filter_sink_port_assertions.sv]
/*
 checker for the sink link between source and filter ends.
 assumes two beats a group and instantiation beside the link.
*/
`timescale 1ns/1ps
`default_nettype none
module fir_filter_sink_port_assertions #(
    parameter int DW = fir_sink_pkg::SLOT_WIDTH * fir_sink_pkg::INPUT_WIRE_COUNT
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic valid,
    input wire logic ready,
    input wire logic sop,
    input wire logic eop,
    input wire logic [DW-1:0] data
);
    // ****
    // link properties
    // ****
    logic beat_ff;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            beat_ff <= 1'b0;
        end else if (valid && ready) begin
            beat_ff <= ~beat_ff;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_reset_quiet;
        $rose(rst_n_i) |-> !ready && !valid;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("link active at reset release");
    property p_ready_up;
        $rose(rst_n_i) |=> ready;
    endproperty
    a_ready_up: assert property (p_ready_up) else $error("ready late after reset");
    property p_hold_offer;
        valid && !ready |=> valid && $stable(data) && $stable(sop) && $stable(eop);
    endproperty
    a_hold_offer: assert property (p_hold_offer) else $error("offer changed before taken");
    property p_one_beat;
        valid && ready |=> !valid;
    endproperty
    a_one_beat: assert property (p_one_beat) else $error("beat offered twice");
    property p_start_first;
        valid && ready && !beat_ff |-> sop && !eop;
    endproperty
    a_start_first: assert property (p_start_first) else $error("group start misplaced");
    property p_end_last;
        valid && ready && beat_ff |-> eop && !sop;
    endproperty
    a_end_last: assert property (p_end_last) else $error("group end misplaced");
    property p_no_both;
        valid |-> !(sop && eop);
    endproperty
    a_no_both: assert property (p_no_both) else $error("start and end together");
    property p_wait_bound;
        valid |-> ##[0:20] ready;
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("offer never accepted");
endmodule : fir_filter_sink_port_assertions
`default_nettype wire

// [sim/tb_fir_filter_sink_port.sv]
/*
 testbench joining source and filter ends over the link.
 assumes package defaults: three wires, two beats a group.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_fir_filter_sink_port;
    // ****
    // bench
    // ****
    localparam int SW = fir_sink_pkg::SAMPLE_WIDTH * fir_sink_pkg::INPUT_WIRE_COUNT;
    localparam int BW = fir_sink_pkg::BANK_WIDTH * fir_sink_pkg::INPUT_WIRE_COUNT;
    logic sys_clk_i = 1'b0;
    logic coeff_clk = 1'b0;
    logic rst_n_i = 1'b0;
    logic coeff_rst = 1'b1;
    logic coeff_load = 1'b0;
    logic stall = 1'b0;
    logic bv = 1'b0;
    logic [SW-1:0] bs = '0;
    logic [BW-1:0] bb = '0;
    logic taken, wv, gs, ge, busy;
    logic [SW-1:0] ws;
    logic [BW-1:0] wb;
    logic [7:0] bi;
    logic wv_nb;
    logic [SW-1:0] ws_nb;
    logic [BW-1:0] wb_nb;
    int error_cnt = 0;
    int compares = 0;
    int beat = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    // unrelated phase on purpose
    always #33 coeff_clk = ~coeff_clk;
    fir_sink_if link ();
    fir_sink_source i_fir_sink_source (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .beat_valid_i(bv),
        .beat_samples_i(bs), .beat_banks_i(bb), .beat_taken_o(taken), .link(link));
    fir_sink_filter i_fir_sink_filter (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .coeff_clk_i(coeff_clk),
        .coeff_rst_i(coeff_rst), .coeff_load_i(coeff_load), .datapath_stall_i(stall), .wire_sample_o(ws),
        .wire_bank_select_o(wb), .wire_valid_o(wv), .beat_index_o(bi), .group_start_o(gs),
        .group_end_o(ge), .reload_busy_o(busy), .link(link));
    fir_filter_sink_port_assertions i_fir_filter_sink_port_assertions (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .valid(link.valid), .ready(link.ready), .sop(link.sop), .eop(link.eop),
        .data(link.data));
    // second filter built without backpressure; the bench drives its link directly
    fir_sink_if link_nb ();
    fir_sink_filter #(.BACKPRESSURE(1'b0)) i_fir_sink_filter_nb (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .coeff_clk_i(coeff_clk), .coeff_rst_i(coeff_rst), .coeff_load_i(coeff_load), .datapath_stall_i(stall),
        .wire_sample_o(ws_nb), .wire_bank_select_o(wb_nb), .wire_valid_o(wv_nb), .beat_index_o(),
        .group_start_o(), .group_end_o(), .reload_busy_o(), .link(link_nb));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    // one beat, then an idle cycle so valid never toggles twice in a step
    task automatic send(input logic [SW-1:0] s, input logic [BW-1:0] b);
        int n;
        n = 0;
        bs = s;
        bb = b;
        bv = 1'b1;
        @(negedge sys_clk_i);
        while (taken !== 1'b1) begin
            n++;
            if (n > 40) begin
                error_cnt++;
                tally_and_finish();
            end
            @(negedge sys_clk_i);
        end
        bv = 1'b0;
        chk(link.data, {b[5:4], s[23:16], b[3:2], s[15:8], b[1:0], s[7:0]});
        chk(wv, 1'b1);
        chk(ws, s);
        chk(wb, b);
        chk(bi, beat);
        chk({gs, ge}, beat ? 2'b01 : 2'b10);
        beat = 1 - beat;
        @(negedge sys_clk_i);
    endtask : send
    task automatic do_reset;
        rst_n_i = 1'b0;
        beat = 0;
        repeat (6) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        chk({link.ready, wv, bi}, 10'h000);
    endtask : do_reset
    initial begin
        link_nb.valid = 1'b0;
        link_nb.sop = 1'b0;
        link_nb.eop = 1'b0;
        link_nb.data = '0;
        do_reset();
        chk($bits(link.data), (fir_sink_pkg::SAMPLE_WIDTH + $clog2(fir_sink_pkg::COEFF_SETS)) * 3);
        coeff_rst = 1'b0;
        @(negedge sys_clk_i);
        chk(link.ready, 1'b1);
        send(24'hFF0180, 6'h3C);
        send(24'h00FE7F, 6'h03);
        send(24'h123456, 6'h21);
        send(24'hA5C33C, 6'h1B);
        $display("test groups done");
        repeat (5) begin
            @(negedge sys_clk_i);
            chk({wv, bi}, 9'h001);
        end
        $display("test idle done");
        stall = 1'b1;
        bs = 24'h55AA55;
        bb = 6'h2A;
        bv = 1'b1;
        repeat (4) begin
            @(negedge sys_clk_i);
            chk(taken, 1'b0);
        end
        chk(link.ready, 1'b0);
        link_nb.data = {2'h1, 8'h3C, 2'h2, 8'hC3, 2'h3, 8'h5A};
        link_nb.sop = 1'b1;
        link_nb.valid = 1'b1;
        @(negedge sys_clk_i);
        link_nb.valid = 1'b0;
        chk({link_nb.ready, wv_nb, wb_nb, ws_nb}, {2'b11, 6'h1B, 24'h3CC35A});
        stall = 1'b0;
        send(24'h55AA55, 6'h2A);
        $display("test stall done");
        @(negedge coeff_clk);
        coeff_load = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        chk({busy, link.ready}, 2'b10);
        @(negedge coeff_clk);
        coeff_rst = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        chk(busy, 1'b0);
        @(negedge coeff_clk);
        coeff_load = 1'b0;
        coeff_rst = 1'b0;
        @(negedge sys_clk_i);
        send(24'h010203, 6'h39);
        $display("test reload done");
        send(24'h0F0F0F, 6'h15);
        do_reset();
        send(24'hF0F0F0, 6'h2A);
        $display("test midrun reset done");
        tally_and_finish();
    end
endmodule : tb_fir_filter_sink_port
`default_nettype wire
